// ### include/duc_pkg.sv
// Shared constants and types for the update, reset and reference control block.
package duc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial frame layout: command on top, channel address next, data last.
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Command codes carried in the top nibble of a frame.
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_MASK_LOAD = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP = 4'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Software reset key: address and data that must both match.
    localparam logic [3:0] SOFT_RESET_ADDR = 4'h0;
    localparam logic [15:0] SOFT_RESET_KEY = 16'h1234;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and field positions of the programmable state.
    localparam logic MASK_BIT_RESET = 1'b0;
    localparam int REF_SETUP_W = 3;
    localparam logic [2:0] REF_SETUP_RESET = 3'h0;
    localparam int REF_ENABLE_BIT = 0;
    localparam logic ZERO_SCALE_BIT = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Settling time of the internal power-on reset, rounded up to whole cycles.
    localparam int CLK_PERIOD_NS = 20;
    localparam int POR_SETTLE_NS = 100;
    localparam int POR_CYCLES = (POR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Control sequence: power-on settle, wait for reset pin release, run.
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } duc_state_e;

    typedef logic [FRAME_BITS-1:0] duc_frame_t;

endpackage : duc_pkg

// ### rtl/duc_serial_shift.sv
// Serial input shifter running on the link clock.
`timescale 1ns/10ps
`default_nettype none
module duc_serial_shift (
    input wire logic link_clk,
    input wire logic frame_n,
    input wire logic sdi,
    output logic [duc_pkg::FRAME_BITS-1:0] shift_word
);
    import duc_pkg::*;

    typedef struct packed {
        duc_frame_t shreg;
    } duc_shift_s;

    duc_shift_s sh_q;
    duc_shift_s sh_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Shift one bit per falling link clock while the frame is open. The last
    // 24 bits win, so an overlong frame still yields a word. The register needs
    // no reset: the control domain reads it only after a frame has filled it.
    always_comb begin
        sh_d = sh_q;
        if (!frame_n) begin
            sh_d.shreg = {sh_q.shreg[FRAME_BITS-2:0], sdi};
        end
    end

    // The link clock may stop between frames; the word then simply holds.
    always_ff @(negedge link_clk) begin
        sh_q <= sh_d;
    end

    assign shift_word = sh_q.shreg;

endmodule : duc_serial_shift
`default_nettype wire

// ### rtl/duc_update_ctrl.sv
// Update mask, double-buffered channel registers, resets and reference control.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Mask-load command stores the sixteen data bits into the update mask.
// - Mask-load ignores the channel address and always writes the whole mask.
// - Mask bits reset to zero; zero leaves the channel under strobe control.
// - A masked channel ignores the load strobe falling edge.
// - Strobe falling edge copies input to DAC register on unmasked channels.
// - With the strobe held low the mask bits are disregarded.
// - Write-input updates input register; DAC register too only if strobe low.
// - Update command copies input to DAC register regardless of strobe.
// - Write-and-update loads both registers regardless of strobe.
// - Hardware reset low clears all channel outputs to zero scale.
// - After reset release outputs hold zero until reprogrammed.
// - While hardware reset is low no output update takes place.
// - Strobe and reset pin activity is ignored during power-on reset.
// - Reset pin low at power-up holds off initialization until released.
// - Power-up sets every output to zero scale until a valid write.
// - Software reset restores power-on state only with address zero and key.
// - Reference setup writes enable bit in data bit zero; one disables.
// - Internal reference is enabled after power-up.
// - Each channel has an input register and a DAC register.
module duc_update_ctrl #(
    parameter int CH = 16,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic frame_n,
    input wire logic sdi,
    input wire logic load_strobe_n,
    input wire logic hw_reset_n,
    output logic [CH-1:0][DW-1:0] dac_code,
    output logic [CH-1:0][DW-1:0] input_code,
    output logic [CH-1:0] update_mask,
    output logic [duc_pkg::REF_SETUP_W-1:0] ref_setup,
    output logic ref_off,
    output logic ready
);
    import duc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Local widths and the bit positions of the three synchronised pins.
    localparam int POR_W = $clog2(POR_CYCLES + 1);
    localparam int PIN_N = 3;
    localparam int PIN_FRAME = 2;
    localparam int PIN_LOAD = 1;
    localparam int PIN_RESET = 0;

    typedef struct packed {
        duc_state_e state;
        logic [POR_W-1:0] por_cnt;
        logic [PIN_N-1:0] sync1;
        logic [PIN_N-1:0] sync2;
        logic frame_prev;
        logic load_prev;
        logic [CH-1:0][DW-1:0] in_reg;
        logic [CH-1:0][DW-1:0] dac_reg;
        logic [CH-1:0] mask;
        logic [REF_SETUP_W-1:0] ref_setup;
        logic ready;
    } duc_ctl_s;

    // Power-on image: all pins idle high, outputs at zero scale, reference on.
    localparam duc_ctl_s CTL_RESET = '{
        state: ST_POR,
        por_cnt: '0,
        sync1: {PIN_N{1'b1}},
        sync2: {PIN_N{1'b1}},
        frame_prev: 1'b1,
        load_prev: 1'b1,
        in_reg: {(CH * DW){ZERO_SCALE_BIT}},
        dac_reg: {(CH * DW){ZERO_SCALE_BIT}},
        mask: {CH{MASK_BIT_RESET}},
        ref_setup: REF_SETUP_RESET,
        ready: 1'b0
    };

    duc_ctl_s ctl_q;
    duc_ctl_s ctl_d;
    duc_frame_t shift_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame field decoding, shared by every command branch below.
    function automatic logic [3:0] frame_cmd(input duc_frame_t w);
        frame_cmd = w[CMD_MSB:CMD_LSB];
    endfunction : frame_cmd

    function automatic logic [3:0] frame_addr(input duc_frame_t w);
        frame_addr = w[ADDR_MSB:ADDR_LSB];
    endfunction : frame_addr

    function automatic logic [DW-1:0] frame_data(input duc_frame_t w);
        frame_data = DW'(w[DATA_MSB:DATA_LSB]);
    endfunction : frame_data

    // An address beyond the last channel selects nothing and is dropped.
    function automatic logic addr_valid(input logic [3:0] a);
        addr_valid = (32'(a) < CH);
    endfunction : addr_valid

    ////////////////////////////////////////////////////////////////////////////////
    // Link-domain shifter. Its word only changes while the frame is open, so
    // once frame select has been seen high through the synchroniser the word is
    // stable and may be sampled here without a further handshake.
    duc_serial_shift u_shift (
        .link_clk(link_clk),
        .frame_n(frame_n),
        .sdi(sdi),
        .shift_word(shift_word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole control domain.
    always_comb begin
        logic frame_rise;
        logic load_fall;
        logic load_low;
        logic rst_low;
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [DW-1:0] data;
        int ch;
        frame_rise = 1'b0;
        load_fall = 1'b0;
        load_low = 1'b0;
        rst_low = 1'b0;
        cmd = 4'h0;
        addr = 4'h0;
        data = '0;
        ch = 0;
        ctl_d = ctl_q;

        // Two-stage synchronisers; only the second stage is read below.
        ctl_d.sync1 = {frame_n, load_strobe_n, hw_reset_n};
        ctl_d.sync2 = ctl_q.sync1;

        // Edge and level views of the synchronised pins.
        frame_rise = !ctl_q.frame_prev && ctl_q.sync2[PIN_FRAME];
        load_fall = ctl_q.load_prev && !ctl_q.sync2[PIN_LOAD];
        load_low = !ctl_q.sync2[PIN_LOAD];
        rst_low = !ctl_q.sync2[PIN_RESET];
        ctl_d.frame_prev = ctl_q.sync2[PIN_FRAME];
        ctl_d.load_prev = ctl_q.sync2[PIN_LOAD];

        // Frame fields, valid whenever frame_rise is high.
        // frame field split
        cmd = frame_cmd(shift_word);
        addr = frame_addr(shift_word);
        data = frame_data(shift_word);
        ch = 32'(addr);

        case (ctl_q.state)
            // power-on ignores pins
            // Edges seen here only refresh the edge history; nothing acts on
            // them, so a strobe or reset toggled during power-on is lost.
            ST_POR: begin
                if (ctl_q.por_cnt == POR_W'(POR_CYCLES - 1)) begin
                    ctl_d.state = ST_WAIT;
                end else begin
                    ctl_d.por_cnt = ctl_q.por_cnt + POR_W'(1);
                end
            end

            // hold until release
            // The reset pin held low at power-up keeps the block here; the
            // zero-scale outputs of the power-on image stand meanwhile.
            ST_WAIT: begin
                if (!rst_low) begin
                    ctl_d.state = ST_RUN;
                end
            end

            ST_RUN: begin
                if (rst_low) begin
                    // clear to zero
                    // Input registers are cleared too, so a later strobe edge
                    // cannot bring back a stale pre-reset value.
                    ctl_d.in_reg = CTL_RESET.in_reg;
                    ctl_d.dac_reg = CTL_RESET.dac_reg;
                    // block while low
                    // Frames and strobe edges are dropped for as long as the
                    // pin is low; nothing below runs in this branch.
                end else begin
                    if (load_fall) begin
                        for (int i = 0; i < CH; i++) begin
                            if (!ctl_q.mask[i]) begin
                                ctl_d.dac_reg[i] = ctl_q.in_reg[i];
                            end
                        end
                    end

                    // act on frame end
                    // A command in the same cycle as a strobe edge is applied
                    // after the copy, so the addressed channel ends with the
                    // command's result.
                    if (frame_rise) begin
                        case (cmd)
                            CMD_WRITE_INPUT: begin
                                if (addr_valid(addr)) begin
                                    ctl_d.in_reg[ch] = data;
                                    if (load_low) begin
                                        ctl_d.dac_reg[ch] = data;
                                    end
                                end
                            end

                            CMD_UPDATE_DAC: begin
                                if (addr_valid(addr)) begin
                                    ctl_d.dac_reg[ch] = ctl_q.in_reg[ch];
                                end
                            end

                            CMD_WRITE_UPDATE: begin
                                if (addr_valid(addr)) begin
                                    ctl_d.in_reg[ch] = data;
                                    ctl_d.dac_reg[ch] = data;
                                end
                            end

                            CMD_MASK_LOAD: begin
                                ctl_d.mask = CH'(data);
                            end

                            // keyed soft reset
                            // A wrong key or address is a silent no-operation.
                            CMD_SOFT_RESET: begin
                                if (addr == SOFT_RESET_ADDR && data == SOFT_RESET_KEY) begin
                                    ctl_d.in_reg = CTL_RESET.in_reg;
                                    ctl_d.dac_reg = CTL_RESET.dac_reg;
                                    ctl_d.mask = CTL_RESET.mask;
                                    ctl_d.ref_setup = CTL_RESET.ref_setup;
                                end
                            end

                            // reference enable bit
                            // The reserved bits are kept as written so software
                            // can read back what it sent.
                            CMD_REF_SETUP: begin
                                ctl_d.ref_setup = data[REF_SETUP_W-1:0];
                            end

                            // Reserved and unlisted codes change nothing here.
                            default: begin
                                ctl_d.ref_setup = ctl_q.ref_setup;
                            end
                        endcase
                    end
                end
            end

            // An illegal state code falls back to the power-on image.
            default: begin
                ctl_d = CTL_RESET;
            end
        endcase

        // Ready is a registered copy of the run state, so the port stays a flop.
        ctl_d.ready = (ctl_d.state == ST_RUN);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.
    // power-up at zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= CTL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    // double-buffered registers
    assign dac_code = ctl_q.dac_reg;
    assign input_code = ctl_q.in_reg;
    assign update_mask = ctl_q.mask;
    assign ref_setup = ctl_q.ref_setup;
    assign ref_off = ctl_q.ref_setup[REF_ENABLE_BIT];
    assign ready = ctl_q.ready;

endmodule : duc_update_ctrl
`default_nettype wire

// ### dv/duc_update_ctrl_checker.sv
// Port-level assertions for the update control block.
`timescale 1ns/10ps
`default_nettype none
module duc_update_ctrl_checker #(
    parameter int CH = 16,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic frame_n,
    input wire logic sdi,
    input wire logic load_strobe_n,
    input wire logic hw_reset_n,
    input wire logic [CH-1:0][DW-1:0] dac_code,
    input wire logic [CH-1:0][DW-1:0] input_code,
    input wire logic [CH-1:0] update_mask,
    input wire logic [duc_pkg::REF_SETUP_W-1:0] ref_setup,
    input wire logic ref_off,
    input wire logic ready
);
    import duc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // cleared power-up state.
    AST_PWR_STATE: assert property ($fell(sys_rst) |-> update_mask == '0
        && dac_code == '0 && ref_off == 1'b0) else $error("power-up state not cleared");
    AST_POR_HOLD: assert property ($fell(sys_rst) |-> !ready [*5])
        else $error("ready rose during power-on settle");
    AST_READY_GATE: assert property ($rose(ready) |-> $past(hw_reset_n))
        else $error("ready rose with reset pin low");
    AST_REF_BIT: assert property ($changed(ref_setup) |-> $past(frame_n) && $past(frame_n, 3)
        && ref_off == ref_setup[REF_ENABLE_BIT]) else $error("reference setup changed off frame end");
    AST_HW_CLEAR: assert property (!hw_reset_n [*4] |=> dac_code == '0 && input_code == '0)
        else $error("reset pin did not clear codes");
    AST_HW_BLOCK: assert property (!hw_reset_n [*6] |-> $stable(dac_code)
        && $stable(update_mask)) else $error("update while reset pin low");
    AST_HOLD_ZERO: assert property ((dac_code == '0 && frame_n && load_strobe_n) [*5]
        |=> dac_code == '0) else $error("outputs left zero without cause");
    AST_STROBE_COPY: assert property (ready && hw_reset_n && frame_n && $fell(load_strobe_n)
        && !update_mask[CH-1] |-> ##4 dac_code[CH-1] == input_code[CH-1])
        else $error("strobe edge did not load top channel");
    AST_STROBE_MASKED: assert property (ready && frame_n && $fell(load_strobe_n)
        && update_mask[0] |-> ##1 $stable(dac_code[0]) [*4])
        else $error("masked channel followed strobe");
    AST_MASK_FRAME: assert property ($changed(update_mask) |-> frame_n && $past(frame_n))
        else $error("mask changed inside a frame");
endmodule : duc_update_ctrl_checker

bind duc_update_ctrl duc_update_ctrl_checker #(.CH(CH), .DW(DW)) u_chk (.clk(clk),
    .sys_rst(sys_rst), .link_clk(link_clk), .frame_n(frame_n), .sdi(sdi),
    .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n), .dac_code(dac_code),
    .input_code(input_code), .update_mask(update_mask), .ref_setup(ref_setup),
    .ref_off(ref_off), .ready(ready));
`default_nettype wire

// ### dv/duc_host_model.sv
// Host side of the serial link: sends whole command frames.
`timescale 1ns/10ps
`default_nettype none
module duc_host_model (
    output logic link_clk,
    output logic frame_n,
    output logic sdi
);
    // The link clock idles low so no falling edge occurs between frames.
    initial begin
        link_clk = 1'b0;
        frame_n = 1'b1;
        sdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // whole 24-bit frame, MSB first.
    task automatic send(input logic [23:0] w);
        #37;
        frame_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            #80 link_clk = 1'b1;
            sdi = w[i];
            #80 link_clk = 1'b0;
        end
        // Deselected line shows the inverse so stale data cannot pass.
        #80 frame_n = 1'b1;
        sdi = ~w[0];
        #200;
    endtask : send
endmodule : duc_host_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the update, reset and reference control block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import duc_pkg::*;
    logic clk;
    logic sys_rst;
    logic load_strobe_n;
    logic hw_reset_n;
    wire logic link_clk;
    wire logic frame_n;
    wire logic sdi;
    logic [15:0][15:0] dac_code;
    logic [15:0][15:0] input_code;
    logic [15:0] update_mask;
    logic [2:0] ref_setup;
    logic ref_off;
    logic ready;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    duc_update_ctrl #(.CH(16), .DW(16)) dut (.clk(clk), .sys_rst(sys_rst),
        .link_clk(link_clk), .frame_n(frame_n), .sdi(sdi), .load_strobe_n(load_strobe_n),
        .hw_reset_n(hw_reset_n), .dac_code(dac_code), .input_code(input_code),
        .update_mask(update_mask), .ref_setup(ref_setup), .ref_off(ref_off), .ready(ready));
    duc_host_model host (.link_clk(link_clk), .frame_n(frame_n), .sdi(sdi));

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running control clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // A hung frame or wait is cut short here; the whole run needs about 3000 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Waits long enough for the pin synchronisers and the decode to land.
    task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        host.send({c, a, d});
        cyc(8);
    endtask : cmd

    task automatic pins(input logic s, input logic h);
        @(posedge clk);
        load_strobe_n <= s;
        hw_reset_n <= h;
        cyc(8);
    endtask : pins

    task automatic wait_ready;
        for (int i = 0; i < 50 && ready !== 1'b1; i++) @(posedge clk);
        chk("ready", 16'h0001, {15'h0000, ready});
    endtask : wait_ready

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_write;
        cmd(CMD_WRITE_INPUT, 4'h3, 16'hA5A5);
        chk("input3", 16'hA5A5, input_code[3]);
        chk("dac3 kept", 16'h0000, dac_code[3]);
        cmd(CMD_UPDATE_DAC, 4'h3, 16'h0000);
        chk("dac3", 16'hA5A5, dac_code[3]);
        chk("input3 kept", 16'hA5A5, input_code[3]);
        cmd(CMD_WRITE_UPDATE, 4'h5, 16'h1357);
        chk("input5", 16'h1357, input_code[5]);
        chk("dac5", 16'h1357, dac_code[5]);
    endtask : t_write

    task automatic t_mask;
        cmd(CMD_MASK_LOAD, 4'hF, 16'h00FF);
        chk("mask", 16'h00FF, update_mask);
        cmd(CMD_WRITE_INPUT, 4'h0, 16'h1111);
        cmd(CMD_WRITE_INPUT, 4'hF, 16'h2222);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        chk("dac0 masked", 16'h0000, dac_code[0]);
        chk("dac15 loaded", 16'h2222, dac_code[15]);
        pins(1'b0, 1'b1);
        cmd(CMD_WRITE_INPUT, 4'h1, 16'h7777);
        chk("dac1 strobe low", 16'h7777, dac_code[1]);
        pins(1'b1, 1'b1);
    endtask : t_mask

    task automatic t_ref_soft;
        cmd(CMD_REF_SETUP, 4'h0, 16'h0001);
        chk("ref_off", 16'h0001, {15'h0000, ref_off});
        chk("ref_setup", 16'h0001, {13'h0000, ref_setup});
        cmd(CMD_SOFT_RESET, 4'h1, SOFT_RESET_KEY);
        cmd(CMD_SOFT_RESET, SOFT_RESET_ADDR, 16'h1235);
        chk("mask kept", 16'h00FF, update_mask);
        cmd(CMD_SOFT_RESET, SOFT_RESET_ADDR, SOFT_RESET_KEY);
        chk("mask cleared", 16'h0000, update_mask);
        chk("dac15 cleared", 16'h0000, dac_code[15]);
        chk("ref on", 16'h0000, {15'h0000, ref_off});
    endtask : t_ref_soft

    task automatic t_hw;
        cmd(CMD_WRITE_UPDATE, 4'h2, 16'hABCD);
        pins(1'b1, 1'b0);
        cmd(CMD_WRITE_UPDATE, 4'h4, 16'h4444);
        chk("dac2 cleared", 16'h0000, dac_code[2]);
        chk("dac4 blocked", 16'h0000, dac_code[4]);
        cmd(CMD_MASK_LOAD, 4'h0, 16'hFFFF);
        chk("mask blocked", 16'h0000, update_mask);
        pins(1'b1, 1'b1);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        chk("dac2 after release", 16'h0000, dac_code[2]);
    endtask : t_hw

    // Second reset with the reset pin low and the strobe toggling meanwhile.
    task automatic t_por;
        @(posedge clk);
        sys_rst <= 1'b1;
        hw_reset_n <= 1'b0;
        cyc(20);
        sys_rst <= 1'b0;
        load_strobe_n <= 1'b0;
        cyc(3);
        load_strobe_n <= 1'b1;
        cyc(30);
        chk("ready held", 16'h0000, {15'h0000, ready});
        hw_reset_n <= 1'b1;
        wait_ready();
        chk("dac0 zero", 16'h0000, dac_code[0]);
    endtask : t_por

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        load_strobe_n = 1'b1;
        hw_reset_n = 1'b1;
        cyc(20);
        sys_rst <= 1'b0;
        wait_ready();
        chk("mask reset", 16'h0000, update_mask);
        chk("ref reset", 16'h0000, {13'h0000, ref_setup});
        chk("dac7 reset", 16'h0000, dac_code[7]);
        t_write();
        t_mask();
        t_ref_soft();
        t_hw();
        t_por();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
